// ==== rtl/eecg_pkg.sv ====
// Notes on behaviour
// R01 - A set chained flag for channels 0 to 31 makes that channel's event a candidate for prioritized submission; a clear flag does nothing.
// R02 - The upper chained flags cover channels 32 to 63, are read-only to software and reset to zero.
// R03 - One enable bit per channel for all 64 channels, set only by the enable-set path and cleared only by the enable-clear path.
// R04 - A latched external event is evaluated for submission only while its channel's enable bit is 1.
// R05 - Every external event is latched whatever the enable, but a latched event of a disabled channel is not processed.
// R06 - Enabling a channel whose latched event is already pending makes that event processed like a new one.
// R07 - Enable bits never gate chained or manually set events.
// R08 - Both halves of the enable mask are read-only to direct writes and reset to zero.
// R09 - A completion with intermediate or final chaining on sets the chained flag indexed by the six-bit code, ignoring enables; servicing clears it.
// R10 - A chaining code for an already set flag raises the missed-event bit; a set and a clear in one cycle leave the flag set.
// R11 - Writing 1 to an enable-set bit sets that enable bit; writing 0 changes nothing.
// R12 - Writing 1 to an enable-clear bit clears that enable bit; writing 0 changes nothing.
// R13 - Reading chained or enable registers returns current flags and has no side effect.
package eecg_pkg;
  localparam int unsigned NUM_CH = 64;
  localparam int unsigned AW     = 6;
  // byte offsets of the register window
  localparam logic [AW-1:0] OFS_CHAIN_LO   = 6'h00;
  localparam logic [AW-1:0] OFS_CHAIN_HI   = 6'h04;
  localparam logic [AW-1:0] OFS_ENABLE_LO  = 6'h08;
  localparam logic [AW-1:0] OFS_ENABLE_HI  = 6'h0c;
  localparam logic [AW-1:0] OFS_EN_SET_LO  = 6'h10;
  localparam logic [AW-1:0] OFS_EN_SET_HI  = 6'h14;
  localparam logic [AW-1:0] OFS_EN_CLR_LO  = 6'h18;
  localparam logic [AW-1:0] OFS_EN_CLR_HI  = 6'h1c;
  localparam logic [63:0]   RST_FLAGS      = 64'h0;
  localparam logic [1:0]    RESP_OKAY      = 2'b00;
  localparam logic [1:0]    RESP_SLVERR    = 2'b10;
  typedef enum logic [0:0] {
    EECG_IDLE = 1'b0,
    EECG_RESP = 1'b1
  } eecg_bus_t;
endpackage

// ==== rtl/eecg_gate.sv ====
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module eecg_gate (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event sources
  input  wire logic [63:0] event_latch,
  input  wire logic [63:0] manual_event,
  // chaining completion
  input  wire logic        chain_done,
  input  wire logic        intermediate_chain_on,
  input  wire logic        final_chain_on,
  input  wire logic [5:0]  completion_code,
  // prioritizer side
  input  wire logic [63:0] chain_serviced,
  output logic [63:0]      latched_eligible,
  output logic [63:0]      chain_pending,
  output logic [63:0]      request_pending,
  output logic [63:0]      missed_chain
);

  // write byte lanes merged into a 32-bit mask
  function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] s);
    lane_mask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  logic [63:0]         chain_r;
  logic [63:0]         chain_nxt;
  logic [63:0]         enable_r;
  logic [63:0]         enable_nxt;
  logic [63:0]         missed_r;
  logic [63:0]         missed_nxt;
  logic [63:0]         chain_hit;
  eecg_pkg::eecg_bus_t wst_r;
  eecg_pkg::eecg_bus_t wst_nxt;
  eecg_pkg::eecg_bus_t rst_st_r;
  eecg_pkg::eecg_bus_t rst_st_nxt;
  logic [5:0]          awaddr_r;
  logic [5:0]          awaddr_nxt;
  logic                aw_have_r;
  logic                aw_have_nxt;
  logic [31:0]         wdata_r;
  logic [31:0]         wdata_nxt;
  logic                w_have_r;
  logic                w_have_nxt;
  logic [1:0]          bresp_r;
  logic [1:0]          bresp_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  logic [1:0]          rresp_r;
  logic [1:0]          rresp_nxt;
  logic                wr_go;
  logic [63:0]         en_set;
  logic [63:0]         en_clr;

  // one-hot decode of the chaining code, only when chaining is selected
  always_comb begin
    chain_hit = 64'h0;
    if (chain_done && (intermediate_chain_on || final_chain_on)) begin
      chain_hit[completion_code] = 1'b1; // R09
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = (wst_r == eecg_pkg::EECG_IDLE) && !aw_have_r;
  assign s_axi_wready  = (wst_r == eecg_pkg::EECG_IDLE) && !w_have_r;
  assign s_axi_bvalid  = (wst_r == eecg_pkg::EECG_RESP);
  assign s_axi_bresp   = bresp_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    awaddr_nxt  = awaddr_r;
    w_have_nxt  = w_have_r;
    wdata_nxt   = wdata_r;
    wst_nxt     = wst_r;
    bresp_nxt   = bresp_r;
    wr_go       = 1'b0;
    en_set      = 64'h0;
    en_clr      = 64'h0;
    case (wst_r)
      eecg_pkg::EECG_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_nxt = 1'b1;
          awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_nxt = 1'b1;
          wdata_nxt  = lane_mask(s_axi_wdata, s_axi_wstrb);
        end
        if (aw_have_r && w_have_r) begin
          wr_go       = 1'b1;
          aw_have_nxt = 1'b0;
          w_have_nxt  = 1'b0;
          wst_nxt     = eecg_pkg::EECG_RESP;
          bresp_nxt   = eecg_pkg::RESP_OKAY;
          case ({awaddr_r[5:2], 2'b00})
            eecg_pkg::OFS_EN_SET_LO: en_set[31:0]  = wdata_r; // R11
            eecg_pkg::OFS_EN_SET_HI: en_set[63:32] = wdata_r; // R11
            eecg_pkg::OFS_EN_CLR_LO: en_clr[31:0]  = wdata_r; // R12
            eecg_pkg::OFS_EN_CLR_HI: en_clr[63:32] = wdata_r; // R12
            // read-only flag words ignore writes
            eecg_pkg::OFS_CHAIN_LO, eecg_pkg::OFS_CHAIN_HI,
            eecg_pkg::OFS_ENABLE_LO, eecg_pkg::OFS_ENABLE_HI: bresp_nxt = eecg_pkg::RESP_OKAY; // R08
            default: bresp_nxt = eecg_pkg::RESP_SLVERR;
          endcase
        end
      end
      eecg_pkg::EECG_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = eecg_pkg::EECG_IDLE;
        end
      end
      default: wst_nxt = eecg_pkg::EECG_IDLE;
    endcase
  end

  // read channel: pure view of flags, no side effects
  assign s_axi_arready = (rst_st_r == eecg_pkg::EECG_IDLE);
  assign s_axi_rvalid  = (rst_st_r == eecg_pkg::EECG_RESP);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    rst_st_nxt = rst_st_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    case (rst_st_r)
      eecg_pkg::EECG_IDLE: begin
        if (s_axi_arvalid) begin
          rst_st_nxt = eecg_pkg::EECG_RESP;
          rresp_nxt  = eecg_pkg::RESP_OKAY;
          case ({s_axi_araddr[5:2], 2'b00})
            eecg_pkg::OFS_CHAIN_LO:  rdata_nxt = chain_r[31:0];   // R13
            eecg_pkg::OFS_CHAIN_HI:  rdata_nxt = chain_r[63:32];  // R02
            eecg_pkg::OFS_ENABLE_LO: rdata_nxt = enable_r[31:0];  // R13
            eecg_pkg::OFS_ENABLE_HI: rdata_nxt = enable_r[63:32]; // R13
            // set and clear words are write-only, read as zero
            eecg_pkg::OFS_EN_SET_LO, eecg_pkg::OFS_EN_SET_HI,
            eecg_pkg::OFS_EN_CLR_LO, eecg_pkg::OFS_EN_CLR_HI: rdata_nxt = 32'h0;
            default: begin
              rdata_nxt = 32'h0;
              rresp_nxt = eecg_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      eecg_pkg::EECG_RESP: begin
        if (s_axi_rready) begin
          rst_st_nxt = eecg_pkg::EECG_IDLE;
        end
      end
      default: rst_st_nxt = eecg_pkg::EECG_IDLE;
    endcase
  end

  // flag next state; set beats clear so no chained event is dropped
  always_comb begin
    chain_nxt  = (chain_r & ~chain_serviced) | chain_hit; // R09 R10
    missed_nxt = missed_r | (chain_r & chain_hit);         // R10
    // clear write wins only if both set and clear hit one bit in one word
    enable_nxt = (enable_r | en_set) & ~en_clr;            // R03
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chain_r   <= eecg_pkg::RST_FLAGS; // R02
      enable_r  <= eecg_pkg::RST_FLAGS; // R08
      missed_r  <= eecg_pkg::RST_FLAGS;
      wst_r     <= eecg_pkg::EECG_IDLE;
      rst_st_r  <= eecg_pkg::EECG_IDLE;
      awaddr_r  <= 6'h00;
      aw_have_r <= 1'b0;
      wdata_r   <= 32'h0;
      w_have_r  <= 1'b0;
      bresp_r   <= eecg_pkg::RESP_OKAY;
      rdata_r   <= 32'h0;
      rresp_r   <= eecg_pkg::RESP_OKAY;
    end else begin
      chain_r   <= chain_nxt;
      enable_r  <= enable_nxt;
      missed_r  <= missed_nxt;
      wst_r     <= wst_nxt;
      rst_st_r  <= rst_st_nxt;
      awaddr_r  <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r   <= wdata_nxt;
      w_have_r  <= w_have_nxt;
      bresp_r   <= bresp_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // gating to the prioritizer; latch kept outside, enable only masks it
  assign latched_eligible = event_latch & enable_r;                        // R04 R05 R06
  assign chain_pending    = chain_r;                                       // R01
  assign request_pending  = latched_eligible | chain_r | manual_event;     // R07
  assign missed_chain     = missed_r;

  // chained flags: set by completion, cleared by service, set wins a tie
  AST_CHAIN_SET: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
    chain_done && (intermediate_chain_on || final_chain_on)
    |=> chain_r[$past(completion_code)])
    else $error("chained flag not set by completion");

  AST_MISSED: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    chain_done && (intermediate_chain_on || final_chain_on) && chain_r[completion_code]
    |=> missed_r[$past(completion_code)])
    else $error("missed bit not raised");

  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    chain_done && (intermediate_chain_on || final_chain_on) && chain_serviced[completion_code]
    |=> chain_r[$past(completion_code)])
    else $error("clear beat set on chained flag");

  AST_CHAIN_CLR: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
    chain_serviced[5] && !(chain_done && (completion_code == 6'h05))
    |=> !chain_r[5])
    else $error("serviced chained flag not cleared");

  AST_CHAIN_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
    chain_r[40] && !chain_serviced[40]
    |=> chain_r[40])
    else $error("chained flag dropped before service");

  // a flag can only rise through a completion; reads and writes never raise it
  AST_CHAIN_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
    !chain_done
    |=> (chain_r & ~$past(chain_r)) == 64'h0)
    else $error("chained flag rose without completion");

  AST_MISSED_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    missed_r[5]
    |=> missed_r[5])
    else $error("missed bit lost");

  AST_MISSED_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    !chain_done
    |=> (missed_r & ~$past(missed_r)) == 64'h0)
    else $error("missed bit rose without completion");

  // enable mask: only the set and clear words move it
  AST_EN_SET: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_EN_SET_LO) && wdata_r[0]
    |=> enable_r[0])
    else $error("enable-set write lost");

  AST_EN_SET_HI: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_EN_SET_HI) && wdata_r[31]
    |=> enable_r[63])
    else $error("upper enable-set write lost");

  AST_EN_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_EN_SET_LO) && !wdata_r[0]
    |=> enable_r[0] == $past(enable_r[0]))
    else $error("zero in set word changed an enable");

  AST_EN_CLR: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_EN_CLR_HI) && wdata_r[31]
    |=> !enable_r[63])
    else $error("enable-clear write lost");

  AST_EN_CLR_LO: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_EN_CLR_LO) && wdata_r[4]
    |=> !enable_r[4])
    else $error("lower enable-clear write lost");

  AST_EN_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R03
    !wr_go
    |=> $stable(enable_r))
    else $error("enable changed without set or clear");

  AST_RO_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_ENABLE_LO)
    |=> $stable(enable_r))
    else $error("direct write moved the enable mask");

  AST_RO_CHAIN: assert property (@(posedge sys_clk) disable iff (!rst_b) // R02
    wr_go && ({awaddr_r[5:2], 2'b00} == eecg_pkg::OFS_CHAIN_HI) && !chain_done && !(|chain_serviced)
    |=> $stable(chain_r))
    else $error("direct write moved the chained flags");

  // request gating towards the prioritizer
  AST_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
    !enable_r[5] && !chain_r[5] && !manual_event[5]
    |-> !request_pending[5])
    else $error("disabled latched event passed");

  AST_LATCH_HIDE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R05
    !enable_r[62]
    |-> !latched_eligible[62])
    else $error("latched event of disabled channel processed");

  AST_LATE_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
    event_latch[1] && enable_r[1]
    |-> latched_eligible[1] && request_pending[1])
    else $error("pending event not taken after enable");

  AST_UNGATED: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
    manual_event[40] || chain_r[40]
    |-> request_pending[40])
    else $error("chained or manual event gated");

  AST_CHAIN_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b) // R01
    chain_r[5]
    |-> chain_pending[5] && request_pending[5])
    else $error("set chained flag not offered");

  // register reads are pure views
  AST_RD_NOEFF: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
    s_axi_arvalid && s_axi_arready && !wr_go
    |=> $stable(enable_r))
    else $error("read disturbed enables");

  AST_RD_CHAIN: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
    s_axi_arvalid && s_axi_arready && ({s_axi_araddr[5:2], 2'b00} == eecg_pkg::OFS_CHAIN_LO)
    |=> s_axi_rdata == $past(chain_r[31:0]))
    else $error("chained word read wrong");

  AST_RD_ENHI: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
    s_axi_arvalid && s_axi_arready && ({s_axi_araddr[5:2], 2'b00} == eecg_pkg::OFS_ENABLE_HI)
    |=> s_axi_rdata == $past(enable_r[63:32]))
    else $error("upper enable word read wrong");

  AST_RESET: assert property (@(posedge sys_clk) // R08
    !rst_b
    |=> chain_r == 64'h0 && enable_r == 64'h0)
    else $error("flags not zero after reset");

  // bus answers stand until taken and come in a fixed time
  AST_B_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn");

  AST_R_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response withdrawn");

  AST_B_AFTER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    aw_have_r && w_have_r && !s_axi_bvalid
    |=> s_axi_bvalid)
    else $error("write response late");

  AST_R_AFTER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read response late");

  AST_SLVERR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_go && awaddr_r[5]
    |=> s_axi_bresp == eecg_pkg::RESP_SLVERR)
    else $error("unmapped write answered okay");

endmodule
`default_nettype wire

// ==== tb/eecg_tc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module eecg_tc_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // commands from the bench
  input  wire logic        fire,
  input  wire logic [5:0]  code,
  input  wire logic        svc_en,
  // gate side
  input  wire logic [63:0] chain_pending,
  output logic             chain_done,
  output logic             intermediate_chain_on,
  output logic             final_chain_on,
  output logic [5:0]       completion_code,
  output logic [63:0]      chain_serviced
);
  // completion pulse; code inverted while idle so a stale code never looks valid
  always_ff @(posedge sys_clk) begin
    chain_done <= rst_b & fire;
    intermediate_chain_on <= fire & code[0];
    final_chain_on <= fire & ~code[0];
    completion_code <= !rst_b ? 6'h00 : fire ? code : ~completion_code;
    // service pulses only every other cycle, like a slow controller
    chain_serviced <= (rst_b & svc_en) ? (chain_pending & ~chain_serviced) : 64'h0;
  end
endmodule
`default_nettype wire

// ==== tb/eecg_gate_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module eecg_gate_tb;
  logic        sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, chain_done, intermediate_chain_on, final_chain_on, fire, svc_en;
  logic [5:0]  s_axi_awaddr, s_axi_araddr, completion_code, code;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [63:0] event_latch, manual_event, chain_serviced, latched_eligible;
  logic [63:0] chain_pending, request_pending, missed_chain, en;
  int          err_total, samples_checked, cyc;
  eecg_gate dut (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_latch, .manual_event, .chain_done,
    .intermediate_chain_on, .final_chain_on, .completion_code, .chain_serviced,
    .latched_eligible, .chain_pending, .request_pending, .missed_chain);
  eecg_tc_model tc (.sys_clk, .rst_b, .fire, .code, .svc_en, .chain_pending, .chain_done,
    .intermediate_chain_on, .final_chain_on, .completion_code, .chain_serviced);
  // handshakes judged at the rising edge itself, drives changed by nba on it
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    logic       b;
    logic [1:0] rs;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge sys_clk);
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", r, rs)
  endtask
  task automatic axi_rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    logic        v;
    logic [31:0] rd;
    logic [1:0]  rs;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(posedge sys_clk);
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK("rresp", r, rs)
    `CHK("rdata", d, rd)
  endtask
  task automatic t_reset();
    axi_rd(6'h00, 32'h0, 2'b00);
    axi_rd(6'h04, 32'h0, 2'b00);
    axi_rd(6'h08, 32'h0, 2'b00);
    axi_rd(6'h0c, 32'h0, 2'b00);
    axi_rd(6'h10, 32'h0, 2'b00);
    axi_rd(6'h20, 32'h0, 2'b10);
  endtask
  task automatic t_enable();
    axi_wr(6'h10, 32'h0000_00f1, 2'b00);
    axi_wr(6'h14, 32'h8000_0001, 2'b00);
    axi_wr(6'h18, 32'h0000_0010, 2'b00);
    axi_wr(6'h08, 32'hffff_ffff, 2'b00);
    axi_wr(6'h04, 32'hffff_ffff, 2'b00);
    axi_wr(6'h20, 32'h1234_5678, 2'b10);
    en = 64'h8000_0001_0000_00e1;
    axi_rd(6'h08, en[31:0], 2'b00);
    axi_rd(6'h0c, en[63:32], 2'b00);
    axi_rd(6'h04, 32'h0, 2'b00);
  endtask
  task automatic t_gating();
    event_latch <= 64'h4000_0001_0000_00ff;
    manual_event <= 64'h0000_0100_0000_0000;
    @(negedge sys_clk);
    `CHK("eligible", event_latch & en, latched_eligible)
    `CHK("pending", 64'h0000_0101_0000_00e1, request_pending)
    axi_wr(6'h10, 32'h0000_0002, 2'b00);
    @(negedge sys_clk);
    `CHK("eligible", 64'h0000_0001_0000_00e3, latched_eligible)
    `CHK("pending", 64'h0000_0101_0000_00e3, request_pending)
    en[1] = 1'b1;
  endtask
  task automatic fire_code(input logic [5:0] c);
    @(posedge sys_clk);
    fire <= 1; code <= c;
    @(posedge sys_clk);
    fire <= 0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic t_chain();
    fire_code(6'd40);
    fire_code(6'd5);
    @(negedge sys_clk);
    `CHK("chain", 64'h0000_0100_0000_0020, chain_pending)
    `CHK("pending", 64'h0000_0101_0000_00e3, request_pending)
    `CHK("missed", 64'h0, missed_chain)
    axi_rd(6'h00, 32'h0000_0020, 2'b00);
    axi_rd(6'h04, 32'h0000_0100, 2'b00);
    axi_rd(6'h04, 32'h0000_0100, 2'b00);
    fire_code(6'd5);
    @(negedge sys_clk);
    `CHK("missed", 64'h0000_0000_0000_0020, missed_chain)
    @(posedge sys_clk);
    svc_en <= 1;
    repeat (4) @(posedge sys_clk);
    svc_en <= 0;
    @(negedge sys_clk);
    `CHK("chain", 64'h0, chain_pending)
    `CHK("pending", 64'h0000_0101_0000_00e3, request_pending)
    `CHK("missed", 64'h0000_0000_0000_0020, missed_chain)
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // free-running clock, 40 ns period
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard, well above the hundred or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {fire, svc_en, s_axi_awaddr, s_axi_araddr, code, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    {event_latch, manual_event, en} = 0;
    err_total = 0; samples_checked = 0; cyc = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1;
    t_reset();
    t_enable();
    t_gating();
    t_chain();
    summarize();
  end
endmodule
`default_nettype wire
